// *** rx_pkg.sv ***
// Constants for the receive lock control and word aligner.
// Assumes one serial bit per clock and a 100 MHz core clock.
package rx_pkg;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PATTERN = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;

  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_PROTO_LSB = 3;
  localparam int CTRL_W10       = 5;
  localparam int CTRL_DOUBLE    = 6;
  localparam int CTRL_QUAD      = 7;
  localparam int CTRL_CMP7      = 8;
  localparam int CTRL_USED      = 9;
  localparam int CTRL_PPM_LSB   = 10;
  localparam int CTRL_RUN_LSB   = 12;

  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;

  localparam int ST_FREQ    = 0;
  localparam int ST_PLL     = 1;
  localparam int ST_SYNC    = 2;
  localparam int ST_ALN16   = 3;
  localparam int ST_CFGERR  = 4;
  localparam int ST_RUNERR  = 5;
  localparam int ST_OFS_LSB = 8;

  localparam logic [2:0] MODE_SLIP = 3'h0;
  localparam logic [2:0] MODE_A16  = 3'h1;
  localparam logic [2:0] MODE_A10  = 3'h2;
  localparam logic [2:0] MODE_XAUI = 3'h3;
  localparam logic [2:0] MODE_GIGE = 3'h4;

  localparam logic [1:0] PROTO_CUSTOM = 2'h0;
  localparam logic [1:0] PROTO_SONET  = 2'h1;
  localparam logic [1:0] PROTO_XAUI   = 2'h2;
  localparam logic [1:0] PROTO_GIGE   = 2'h3;

  localparam logic [10:0] PPM_THR_0 = 11'h07D;
  localparam logic [10:0] PPM_THR_1 = 11'h0FA;
  localparam logic [10:0] PPM_THR_2 = 11'h1F4;
  localparam logic [10:0] PPM_THR_3 = 11'h3E8;
  // Phase measured in hundredths of a unit interval
  localparam logic [6:0]  PHASE_MAX = 7'h08;

  localparam logic [7:0] RUN_STEP10 = 8'h05;
  localparam logic [7:0] RUN_STEP8  = 8'h04;

  localparam logic [9:0] K285_NEG  = 10'h17C;
  localparam logic [2:0] SYNC_BAD  = 3'h4;
  localparam logic [3:0] LAST_W10  = 4'h9;
  localparam logic [3:0] LAST_W8   = 4'h7;

  function automatic logic [10:0] ppm_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0:    ppm_limit = PPM_THR_0;
      2'h1:    ppm_limit = PPM_THR_1;
      2'h2:    ppm_limit = PPM_THR_2;
      default: ppm_limit = PPM_THR_3;
    endcase
  endfunction

  function automatic logic [7:0] run_limit(input logic [4:0] sel,
                                           input logic       w10);
    logic [15:0] p;
    p = ({11'h000, sel} + 16'h0001) * {8'h00, (w10 ? RUN_STEP10 : RUN_STEP8)};
    run_limit = p[7:0];
  endfunction

endpackage

// *** cru_lock_ctrl.sv ***
// Lock mode selection for the clock recovery unit.
// Inputs are already synchronised to i_ref_clk by the parent.
`timescale 1ns/1ps
module cru_lock_ctrl (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_force_data,
  input  wire logic        i_force_ref,
  input  wire logic        i_pll_lock,
  input  wire logic        i_power_down,
  input  wire logic [1:0]  i_ppm_sel,
  input  wire logic [10:0] i_ppm_meas,
  input  wire logic [6:0]  i_phase_meas,
  output logic             o_to_data,
  output logic             o_locked_n
);

  logic freq_ok;
  logic phase_ok;
  logic next_to_data;

  always_comb
  begin
    freq_ok  = i_ppm_meas <= rx_pkg::ppm_limit(i_ppm_sel);
    phase_ok = i_phase_meas <= rx_pkg::PHASE_MAX;
    if (i_power_down)
      next_to_data = 1'b0;
    else if (i_force_data)
      next_to_data = 1'b1;
    else if (i_force_ref)
      next_to_data = 1'b0;
    else if (o_to_data)
      next_to_data = freq_ok;
    else
      next_to_data = freq_ok && phase_ok && i_pll_lock;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_to_data <= 1'b0;
    else
      o_to_data <= next_to_data;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_locked_n <= 1'b1;
    else
      o_locked_n <= i_power_down || !i_pll_lock;
  end

endmodule

// *** serdes_rx_lock_word_align.sv ***
// Receive channel: lock control, deserializer, run length check and word aligner.
// Assumes one serial bit per i_ref_clk and a register master on the same clock.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module serdes_rx_lock_word_align (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_rx_serial,
  input  wire logic        i_force_data_lock,
  input  wire logic        i_force_ref_lock,
  input  wire logic        i_pll_lock,
  input  wire logic [10:0] i_ppm_meas,
  input  wire logic [6:0]  i_phase_meas,
  input  wire logic        i_bit_slip,
  input  wire logic        i_realign,
  input  wire logic        i_align_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output logic      [31:0] o_rd_data,
  output logic      [9:0]  o_word,
  output logic             o_word_valid,
  output logic             o_pattern_det,
  output logic             o_sync_ok,
  output logic             o_freq_locked,
  output logic             o_pll_locked_n,
  output logic             o_cru_power_down,
  output logic             o_run_err
);

  typedef enum logic [4:0] {
    SYNC_LOSS = 5'h01,
    SYNC_ACQ1 = 5'h02,
    SYNC_ACQ2 = 5'h04,
    SYNC_ACQ3 = 5'h08,
    SYNC_DONE = 5'h10
  } sync_e;

  localparam int PIN_W = 22;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             rx_bit;
  logic             force_data;
  logic             force_ref;
  logic             pll_lock;
  logic [10:0]      ppm_s;
  logic [6:0]       phase_s;

  logic [31:0] ctrl;
  logic [31:0] pattern;
  logic [2:0]  mode;
  logic [1:0]  proto;
  logic        w10;
  logic        quad;
  logic        cmp7;
  logic        used;

  logic [31:0] hist;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [3:0]  wlast;
  logic        at_end;
  logic        cfg_ok;
  logic        hit;
  logic        pdet;
  logic        may_align;
  logic        realign;
  logic        slip_prev;
  logic        slip_go;
  logic        word_end;
  logic        aligned16;
  logic        comma_ok;
  logic        comma_bad;
  sync_e       sync_st;
  sync_e       next_sync;
  logic [2:0]  bad_cnt;
  logic [7:0]  run_len;
  logic [7:0]  run_max;
  logic        run_clr;
  logic [31:0] status;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // Both polarities of a 10-bit code, optionally on the lower seven bits
  function automatic logic match10(input logic [9:0] win,
                                   input logic [9:0] pat,
                                   input logic       low7);
    if (low7)
      match10 = (win[6:0] == pat[6:0]) || (win[6:0] == ~pat[6:0]);
    else
      match10 = (win == pat) || (win == ~pat);
  endfunction

  // Allowed pairing of aligner mode, protocol and path width
  function automatic logic mode_legal(input logic [2:0] md,
                                      input logic [1:0] pr,
                                      input logic       wide,
                                      input logic       four);
    logic cs;
    cs = (pr == rx_pkg::PROTO_CUSTOM) || (pr == rx_pkg::PROTO_SONET);
    unique case (md)
      rx_pkg::MODE_SLIP: mode_legal = cs;
      rx_pkg::MODE_A16:
        mode_legal = cs && !wide && !(four && pr != rx_pkg::PROTO_SONET);
      rx_pkg::MODE_A10:  mode_legal = wide && pr == rx_pkg::PROTO_CUSTOM;
      rx_pkg::MODE_XAUI: mode_legal = wide && pr == rx_pkg::PROTO_XAUI;
      rx_pkg::MODE_GIGE: mode_legal = wide && pr == rx_pkg::PROTO_GIGE;
      default:           mode_legal = 1'b0;
    endcase
  endfunction

  // Pin inputs pass two flip-flops
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {i_rx_serial, i_force_data_lock, i_force_ref_lock,
                   i_pll_lock, i_ppm_meas, i_phase_meas};
      pin_sync <= pin_meta;
    end
  end

  assign {rx_bit, force_data, force_ref, pll_lock, ppm_s, phase_s} = pin_sync;

  assign mode  = ctrl[rx_pkg::CTRL_MODE_LSB +: 3];
  assign proto = ctrl[rx_pkg::CTRL_PROTO_LSB +: 2];
  assign w10   = ctrl[rx_pkg::CTRL_W10];
  assign quad  = ctrl[rx_pkg::CTRL_QUAD];
  assign cmp7  = ctrl[rx_pkg::CTRL_CMP7];
  assign used  = ctrl[rx_pkg::CTRL_USED];

  // Register writes
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl    <= rx_pkg::CTRL_RESET;
      pattern <= rx_pkg::PATTERN_RESET;
    end
    else if (i_wr_stb)
    begin
      if (i_addr == rx_pkg::ADDR_CTRL)
        ctrl <= i_wr_data;
      if (i_addr == rx_pkg::ADDR_PATTERN)
        pattern <= i_wr_data;
    end
  end

  assign run_clr = i_wr_stb && i_addr == rx_pkg::ADDR_STATUS &&
                   i_wr_data[rx_pkg::ST_RUNERR];

  always_comb
  begin
    status = '0;
    status[rx_pkg::ST_FREQ]   = o_freq_locked;
    status[rx_pkg::ST_PLL]    = !o_pll_locked_n;
    status[rx_pkg::ST_SYNC]   = o_sync_ok;
    status[rx_pkg::ST_ALN16]  = aligned16;
    status[rx_pkg::ST_CFGERR] = !cfg_ok;
    status[rx_pkg::ST_RUNERR] = o_run_err;
    status[rx_pkg::ST_OFS_LSB +: 4] = cnt;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || !i_rd_stb)
      o_rd_data <= '0;
    else
    begin
      unique case (i_addr)
        rx_pkg::ADDR_CTRL:    o_rd_data <= ctrl;
        rx_pkg::ADDR_PATTERN: o_rd_data <= pattern;
        rx_pkg::ADDR_STATUS:  o_rd_data <= status;
        default:              o_rd_data <= '0;
      endcase
    end
  end

  // Lock control
  cru_lock_ctrl u_lock (
    .i_ref_clk    (i_ref_clk),
    .i_sys_rst    (i_sys_rst),
    .i_force_data (force_data),
    .i_force_ref  (force_ref),
    .i_pll_lock   (pll_lock),
    .i_power_down (!used),
    .i_ppm_sel    (ctrl[rx_pkg::CTRL_PPM_LSB +: 2]),
    .i_ppm_meas   (ppm_s),
    .i_phase_meas (phase_s),
    .o_to_data    (o_freq_locked),
    .o_locked_n   (o_pll_locked_n)
  );

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_cru_power_down <= 1'b1;
    else
      o_cru_power_down <= !used;
  end

  // Serial history, oldest bit lowest
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      hist <= '0;
    else
      hist <= {rx_bit, hist[31:1]};
  end

  // Run length check
  assign run_max = rx_pkg::run_limit(ctrl[rx_pkg::CTRL_RUN_LSB +: 5], w10);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      run_len <= 8'h00;
    else if (hist[31] != hist[30])
      run_len <= 8'h01;
    else if (run_len != 8'hFF)
      run_len <= run_len + 8'h01;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_run_err <= 1'b0;
    else if (run_len >= run_max)
      o_run_err <= 1'b1;
    else if (run_clr)
      o_run_err <= 1'b0;
  end

  // Aligner decode
  always_comb
  begin
    cfg_ok = mode_legal(mode, proto, w10, quad);
    wlast  = w10 ? rx_pkg::LAST_W10 : rx_pkg::LAST_W8;
    at_end = cnt == wlast;
    hit    = 1'b0;
    may_align = 1'b0;
    unique case (mode)
      rx_pkg::MODE_A16:
      begin
        hit = quad ? hist == pattern : hist[31:16] == pattern[15:0];
        may_align = !aligned16;
      end
      rx_pkg::MODE_A10:
      begin
        hit = match10(hist[31:22], pattern[9:0], cmp7);
        may_align = i_align_en;
      end
      rx_pkg::MODE_XAUI, rx_pkg::MODE_GIGE:
      begin
        hit = match10(hist[31:22], rx_pkg::K285_NEG, 1'b0);
        may_align = sync_st == SYNC_LOSS;
      end
      default:
      begin
        hit = 1'b0;
        may_align = 1'b0;
      end
    endcase
    if (mode == rx_pkg::MODE_SLIP)
      pdet = w10 ? hist[31:22] == pattern[9:0] : hist[31:24] == pattern[7:0];
    else
      pdet = hit;
    realign   = cfg_ok && hit && may_align;
    slip_go   = cfg_ok && mode == rx_pkg::MODE_SLIP && i_bit_slip && !slip_prev;
    word_end  = cfg_ok && !slip_go && (at_end || realign);
    comma_ok  = cfg_ok && (mode == rx_pkg::MODE_XAUI || mode == rx_pkg::MODE_GIGE)
                && hit && at_end;
    comma_bad = cfg_ok && (mode == rx_pkg::MODE_XAUI || mode == rx_pkg::MODE_GIGE)
                && hit && !at_end;
    if (!cfg_ok)
      next_cnt = 4'h0;
    else if (slip_go)
      next_cnt = cnt;
    else if (word_end)
      next_cnt = 4'h0;
    else
      next_cnt = cnt + 4'h1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      cnt       <= 4'h0;
      slip_prev <= 1'b0;
    end
    else
    begin
      cnt       <= next_cnt;
      slip_prev <= i_bit_slip;
    end
  end

  // Word output on the current boundary
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_word        <= '0;
      o_word_valid  <= 1'b0;
      o_pattern_det <= 1'b0;
    end
    else
    begin
      o_word_valid  <= word_end;
      o_pattern_det <= word_end && pdet;
      if (word_end)
        o_word <= w10 ? hist[31:22] : {2'h0, hist[31:24]};
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || mode != rx_pkg::MODE_A16)
      aligned16 <= 1'b0;
    else if (realign)
      aligned16 <= 1'b1;
    else if (i_realign)
      aligned16 <= 1'b0;
  end

  // Comma synchronisation
  always_comb
  begin
    next_sync = sync_st;
    unique case (sync_st)
      SYNC_LOSS: if (realign) next_sync = SYNC_ACQ1;
      SYNC_ACQ1: if (comma_ok) next_sync = SYNC_ACQ2;
                 else if (comma_bad) next_sync = SYNC_LOSS;
      SYNC_ACQ2: if (comma_ok) next_sync = SYNC_ACQ3;
                 else if (comma_bad) next_sync = SYNC_LOSS;
      SYNC_ACQ3: if (comma_ok) next_sync = SYNC_DONE;
                 else if (comma_bad) next_sync = SYNC_LOSS;
      SYNC_DONE: if (comma_bad && bad_cnt == rx_pkg::SYNC_BAD - 3'h1)
                   next_sync = SYNC_LOSS;
      default:   next_sync = SYNC_LOSS;
    endcase
    if (!cfg_ok || !(mode == rx_pkg::MODE_XAUI || mode == rx_pkg::MODE_GIGE))
      next_sync = SYNC_LOSS;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      sync_st <= SYNC_LOSS;
    else
      sync_st <= next_sync;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || sync_st != SYNC_DONE || comma_ok)
      bad_cnt <= 3'h0;
    else if (comma_bad)
      bad_cnt <= bad_cnt + 3'h1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_sync_ok <= 1'b0;
    else
      o_sync_ok <= next_sync == SYNC_DONE;
  end

  sequence s_acq3_comma;
    sync_st == SYNC_ACQ3 && comma_ok && cfg_ok;
  endsequence

  sequence s_a10_hit;
    mode == rx_pkg::MODE_A10 && cfg_ok && i_align_en && hit && !slip_go;
  endsequence

  a_word_lsb_first:
    assert property (o_word_valid && w10 && $past(w10, 12) |->
                     o_word[0] == $past(rx_bit, 11) && o_word[9] == $past(rx_bit, 2))
    else $error("word bit order wrong");

  a_force_data:
    assert property (force_data && used |=> o_freq_locked)
    else $error("forced data lock ignored");

  a_force_ref:
    assert property (!force_data && force_ref |=> !o_freq_locked)
    else $error("forced reference lock ignored");

  a_auto_switch:
    assert property ($rose(o_freq_locked) && !$past(force_data) |->
                     $past(ppm_s) <= rx_pkg::ppm_limit($past(ctrl[11:10])) &&
                     $past(phase_s) <= rx_pkg::PHASE_MAX)
    else $error("data lock taken outside limits");

  a_power_down:
    assert property (!used |=> o_cru_power_down && !o_freq_locked && o_pll_locked_n)
    else $error("unused channel not powered down");

  a_run_flag:
    assert property (run_len >= run_max |=> o_run_err)
    else $error("run length flag missed");

  a_slip_hold:
    assert property (slip_go |=> cnt == $past(cnt) && !o_word_valid)
    else $error("slip did not delay the boundary");

  a_cfg_block:
    assert property (!cfg_ok |=> !o_word_valid && cnt == 4'h0)
    else $error("illegal configuration produced words");

  a_align_ten:
    assert property (s_a10_hit |=> o_word_valid && o_pattern_det ##1 cnt == 4'h1)
    else $error("10-bit pattern not aligned");

  a_sync_reach:
    assert property (s_acq3_comma |=> sync_st == SYNC_DONE && o_sync_ok)
    else $error("sync not reached after third comma");

endmodule

// *** tx_model.sv ***
// Remote serial transmitter: sends queued 10-bit words, first bit the LSB.
// Assumes one bit per i_ref_clk; the line toggles while nothing is queued.
`timescale 1ns/1ps
module tx_model (
  input  wire logic i_ref_clk,
  output logic      o_serial
);
  logic [9:0] q[$];
  logic [9:0] sh;
  int         cnt;
  initial
  begin
    o_serial = 1'b0;
    cnt = 0;
  end
  task automatic send(input logic [9:0] w);
    q.push_back(w);
  endtask
  always @(posedge i_ref_clk)
  begin
    if (cnt == 0 && q.size() != 0)
    begin
      sh = q.pop_front();
      cnt = 10;
    end
    if (cnt != 0)
    begin
      o_serial <= sh[0];
      sh = sh >> 1;
      cnt = cnt - 1;
    end
    else
      o_serial <= ~o_serial;
  end
endmodule

// *** test_serdes_rx_lock_word_align.sv ***
// Self-checking bench for the receive lock control and word aligner.
// Assumes tx_model drives the serial pin and a 100 MHz clock.
`timescale 1ns/1ps
module test_serdes_rx_lock_word_align;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_force_data_lock = 1'b0;
  logic        i_force_ref_lock = 1'b0;
  logic        i_pll_lock = 1'b0;
  logic [10:0] i_ppm_meas = 11'h7FF;
  logic [6:0]  i_phase_meas = 7'h00;
  logic        i_align_en = 1'b1;
  logic        i_bit_slip = 1'b0;
  logic        i_realign = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0000_0000;
  logic        i_wr_stb = 1'b0;
  logic        i_rd_stb = 1'b0;
  wire         i_rx_serial;
  logic [31:0] o_rd_data;
  logic [9:0]  o_word;
  logic        o_word_valid, o_pattern_det, o_sync_ok, o_freq_locked;
  logic        o_pll_locked_n, o_cru_power_down, o_run_err;
  int          num_errors = 0;
  int          n_tests = 0;
  int          seed = 37784;
  logic [31:0] d;
  logic [9:0]  expq[$];
  logic [9:0]  w;
  int          k;
  always #5 i_ref_clk = ~i_ref_clk;
  tx_model tx_u (.i_ref_clk(i_ref_clk), .o_serial(i_rx_serial));
  serdes_rx_lock_word_align dut_u (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_rx_serial(i_rx_serial),
    .i_force_data_lock(i_force_data_lock), .i_force_ref_lock(i_force_ref_lock),
    .i_pll_lock(i_pll_lock), .i_ppm_meas(i_ppm_meas), .i_phase_meas(i_phase_meas),
    .i_bit_slip(i_bit_slip), .i_realign(i_realign), .i_align_en(i_align_en),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data), .o_word(o_word), .o_word_valid(o_word_valid),
    .o_pattern_det(o_pattern_det), .o_sync_ok(o_sync_ok),
    .o_freq_locked(o_freq_locked), .o_pll_locked_n(o_pll_locked_n),
    .o_cru_power_down(o_cru_power_down), .o_run_err(o_run_err));
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      num_errors++;
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_reg({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    @(negedge i_ref_clk);
    v = o_rd_data;
  endtask
  task automatic settle;
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  function automatic logic [31:0] ctrl_val(input logic [2:0] m, input logic [1:0] p,
                                           input logic wd, input logic qd);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[2:0] = m;
    v[4:3] = p;
    v[rx_pkg::CTRL_W10] = wd;
    v[rx_pkg::CTRL_QUAD] = qd;
    v[rx_pkg::CTRL_USED] = 1'b1;
    return v;
  endfunction
  function automatic logic [10:0] lim(input int s);
    return 11'h07D << s;
  endfunction
  task automatic cfg_case(input logic [2:0] m, input logic [1:0] p, input logic wd,
                          input logic qd, input logic bad);
    wr(rx_pkg::ADDR_CTRL, ctrl_val(m, p, wd, qd));
    rd(rx_pkg::ADDR_STATUS, d);
    chk_bit(d[rx_pkg::ST_CFGERR], bad, "config check");
  endtask
  task automatic wait_valid(input int n);
    k = 0;
    do
    begin
      @(negedge i_ref_clk);
      k++;
    end
    while (o_word_valid !== 1'b1 && k < n);
    if (k >= n)
    begin
      $display("mismatch at %0t: word timeout", $time);
      num_errors++;
      results();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_ref_clk);
    chk_bit(o_pll_locked_n, 1'b1, "locked_n reset");
    chk_bit(o_cru_power_down, 1'b1, "power down reset");
    rd(rx_pkg::ADDR_CTRL, d);
    chk_reg(d, rx_pkg::CTRL_RESET, "ctrl reset");
    rd(8'h3C, d);
    chk_reg(d, 32'h0000_0000, "unmapped read");
    i_pll_lock <= 1'b1;
    settle();
    chk_bit(o_pll_locked_n, 1'b1, "unused channel");
    wr(rx_pkg::ADDR_CTRL, ctrl_val(rx_pkg::MODE_SLIP, rx_pkg::PROTO_CUSTOM, 1'b0, 1'b0));
    settle();
    chk_bit(o_cru_power_down, 1'b0, "power up");
    chk_bit(o_pll_locked_n, 1'b0, "pll locked");
    i_force_data_lock <= 1'b1;
    i_force_ref_lock <= 1'b1;
    settle();
    chk_bit(o_freq_locked, 1'b1, "force data");
    i_force_data_lock <= 1'b0;
    settle();
    chk_bit(o_freq_locked, 1'b0, "force ref");
    i_force_ref_lock <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      wr(rx_pkg::ADDR_CTRL, ctrl_val(rx_pkg::MODE_SLIP, rx_pkg::PROTO_CUSTOM, 1'b0, 1'b0)
         | (s << rx_pkg::CTRL_PPM_LSB));
      i_ppm_meas <= lim(s) + 11'h001;
      settle();
      chk_bit(o_freq_locked, 1'b0, "ppm over limit");
      i_ppm_meas <= lim(s);
      i_phase_meas <= 7'h09;
      settle();
      chk_bit(o_freq_locked, 1'b0, "phase too far");
      i_phase_meas <= 7'($unsigned($random(seed)) % 9);
      settle();
      chk_bit(o_freq_locked, 1'b1, "auto lock");
      i_ppm_meas <= 11'($unsigned($random(seed)) % (lim(s) + 1));
      settle();
      chk_bit(o_freq_locked, 1'b1, "auto hold");
    end
    wait_valid(20);
    wait_valid(20);
    chk_reg(k, 8, "word period");
    @(posedge i_ref_clk);
    i_bit_slip <= 1'b1;
    @(posedge i_ref_clk);
    i_bit_slip <= 1'b0;
    wait_valid(20);
    chk_reg(k, 8, "slip period");
    cfg_case(rx_pkg::MODE_SLIP, rx_pkg::PROTO_SONET, 1'b1, 1'b0, 1'b0);
    cfg_case(rx_pkg::MODE_SLIP, rx_pkg::PROTO_XAUI, 1'b1, 1'b0, 1'b1);
    cfg_case(rx_pkg::MODE_A16, rx_pkg::PROTO_SONET, 1'b0, 1'b1, 1'b0);
    cfg_case(rx_pkg::MODE_A16, rx_pkg::PROTO_CUSTOM, 1'b0, 1'b1, 1'b1);
    cfg_case(rx_pkg::MODE_A16, rx_pkg::PROTO_CUSTOM, 1'b1, 1'b0, 1'b1);
    cfg_case(rx_pkg::MODE_A10, rx_pkg::PROTO_SONET, 1'b1, 1'b0, 1'b1);
    cfg_case(rx_pkg::MODE_XAUI, rx_pkg::PROTO_GIGE, 1'b1, 1'b0, 1'b1);
    cfg_case(rx_pkg::MODE_GIGE, rx_pkg::PROTO_GIGE, 1'b1, 1'b0, 1'b0);
    wr(rx_pkg::ADDR_PATTERN, 32'h0000_AAAA);
    wr(rx_pkg::ADDR_CTRL, ctrl_val(rx_pkg::MODE_A16, rx_pkg::PROTO_CUSTOM, 1'b0, 1'b0));
    settle();
    rd(rx_pkg::ADDR_STATUS, d);
    chk_bit(d[rx_pkg::ST_ALN16], 1'b1, "16-bit aligned");
    @(posedge i_ref_clk);
    i_realign <= 1'b1;
    @(posedge i_ref_clk);
    i_realign <= 1'b0;
    settle();
    rd(rx_pkg::ADDR_STATUS, d);
    chk_bit(d[rx_pkg::ST_ALN16], 1'b1, "16-bit rearmed");
    wr(rx_pkg::ADDR_PATTERN, {22'h0, rx_pkg::K285_NEG});
    wr(rx_pkg::ADDR_CTRL, ctrl_val(rx_pkg::MODE_A10, rx_pkg::PROTO_CUSTOM, 1'b1, 1'b0)
       | (32'h0000_0001 << rx_pkg::CTRL_RUN_LSB));
    wr(rx_pkg::ADDR_STATUS, 32'h0000_0001 << rx_pkg::ST_RUNERR);
    rd(rx_pkg::ADDR_STATUS, d);
    chk_bit(d[rx_pkg::ST_RUNERR], 1'b0, "run flag cleared");
    tx_u.send(rx_pkg::K285_NEG);
    for (int i = 0; i < 14; i++)
    begin
      w = (i < 2) ? 10'h000 : (i == 7) ? ~rx_pkg::K285_NEG : 10'($random(seed));
      tx_u.send(w);
      expq.push_back(w);
    end
    k = 0;
    do
    begin
      @(negedge i_ref_clk);
      k++;
    end
    while (o_pattern_det !== 1'b1 && k < 300);
    if (k >= 300)
    begin
      $display("mismatch at %0t: pattern timeout", $time);
      num_errors++;
      results();
    end
    chk_reg({22'h0, o_word}, {22'h0, rx_pkg::K285_NEG}, "aligned word");
    @(posedge i_ref_clk);
    i_align_en <= 1'b0;
    while (expq.size() != 0)
    begin
      w = expq.pop_front();
      wait_valid(20);
      chk_reg({22'h0, o_word}, {22'h0, w}, "word");
      chk_bit(o_pattern_det, w == rx_pkg::K285_NEG || w == ~rx_pkg::K285_NEG,
              "pattern flag");
    end
    chk_bit(o_run_err, 1'b1, "run length");
    wr(rx_pkg::ADDR_CTRL, ctrl_val(rx_pkg::MODE_GIGE, rx_pkg::PROTO_GIGE, 1'b1, 1'b0));
    settle();
    chk_bit(o_sync_ok, 1'b0, "sync idle");
    repeat (5) tx_u.send(rx_pkg::K285_NEG);
    repeat (80) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk_bit(o_sync_ok, 1'b1, "sync acquired");
    results();
  end
endmodule
